// [pcf_pkg.sv]
package pcf_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int unsigned PIN_COUNT   = 4;
    localparam int unsigned REG_WIDTH   = 8;
    localparam int unsigned ADR_WIDTH   = 8;
    localparam int unsigned DAT_WIDTH   = 32;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_IRQ_CONTROL = 8'h00;
    localparam logic [7:0] OFS_RISE_ENABLE = 8'h04;
    localparam logic [7:0] OFS_FALL_ENABLE = 8'h08;
    localparam logic [7:0] OFS_CHANGE_FLAG = 8'h0C;
    localparam logic [7:0] OFS_EVT_STATUS  = 8'h10;
    localparam logic [7:0] OFS_EVT_MASK    = 8'h14;

    // ****************************************
    // irq_control_reg field positions
    // ****************************************
    localparam int unsigned BIT_GLOBAL_IRQ_EN     = 7;
    localparam int unsigned BIT_PERIPHERAL_IRQ_EN = 6;
    localparam int unsigned BIT_CHANGE_IRQ_EN     = 3;
    localparam int unsigned BIT_CHANGE_IRQ_SUM    = 0;

    // ****************************************
    // values after reset
    // ****************************************
    localparam logic [3:0] RST_PIN_BITS = 4'h0;
    localparam logic       RST_BIT      = 1'b0;
endpackage

// [pcf_edge_det.sv]
`timescale 1ns/100ps
module pcf_edge_det #(
    parameter int unsigned WIDTH = 4
) (
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_sys_rst,
    // pin levels
    input  wire logic [WIDTH-1:0] i_pin,
    // one-cycle edge pulses
    output logic      [WIDTH-1:0] o_rise,
    output logic      [WIDTH-1:0] o_fall
);
    logic [WIDTH-1:0] prev_reg;
    logic             primed_reg;

    // previous level; the first cycle after reset only loads, so a pin
    // that is already high at release does not look like a rising edge
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            prev_reg   <= '0;
            primed_reg <= 1'b0;
        end else begin
            prev_reg   <= i_pin;
            primed_reg <= 1'b1;
        end
    end

    // compare with last cycle: one pulse per edge
    assign o_rise = primed_reg ? (i_pin & ~prev_reg) : '0;  // R11
    assign o_fall = primed_reg ? (~i_pin & prev_reg) : '0;  // R11
endmodule

// [pcf_top.sv]
// Functional notes
// R1: a rising edge on a pin whose rise enable is one sets that pin's change flag.
// R2: a falling edge on a pin whose fall enable is one sets that pin's change flag.
// R3: a change flag reads zero after reset until an enabled edge, and after software writes zero.
// R4: a set change flag requests an interrupt only while the change interrupt enable is set.
// R5: bits 7 to 4 of the change flag register always read zero.
// R6: change flag bits 3 to 0 each belong to the port pin of the same index.
// R7: an enabled edge during a clearing write leaves that pin's flag set whatever was written.
// R8: the summary bit of the interrupt control register is the OR of the four change flags.
// R9: edges are detected and flags set even while the change interrupt enable is clear.
// R10: with the change interrupt enable set, an enabled edge wakes the device from sleep.
// R11: edges are found by comparing each pin level with its value one clock earlier.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
module pcf_top
    import pcf_pkg::*;
#(
    parameter int unsigned PINS = pcf_pkg::PIN_COUNT
) (
    // clock and reset
    input  wire logic                           i_sys_clk,
    input  wire logic                           i_sys_rst,
    // wishbone slave
    input  wire logic                           i_wb_cyc,
    input  wire logic                           i_wb_stb,
    input  wire logic                           i_wb_we,
    input  wire logic [pcf_pkg::ADR_WIDTH-1:0]  i_wb_adr,
    input  wire logic [3:0]                     i_wb_sel,
    input  wire logic [pcf_pkg::DAT_WIDTH-1:0]  i_wb_dat,
    output logic      [pcf_pkg::DAT_WIDTH-1:0]  o_wb_dat,
    output logic                                o_wb_ack,
    // port pins
    input  wire logic [PINS-1:0]                i_port_pin,
    // processor side
    input  wire logic                           i_sleep,
    output logic                                o_change_irq,
    output logic                                o_wake,
    output logic                                o_irq
);
    import pcf_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    // software-visible state
    logic [PINS-1:0] rise_enable_reg;
    logic [PINS-1:0] fall_enable_reg;
    logic [PINS-1:0] change_flag_reg;
    logic [PINS-1:0] change_flag_next;
    logic            change_irq_enable_reg;
    logic            global_irq_enable_reg;
    logic            peripheral_irq_enable_reg;
    logic [PINS-1:0] evt_status_reg;
    logic [PINS-1:0] evt_mask_reg;
    logic            ack_reg;
    logic [DAT_WIDTH-1:0] rdat_reg;
    logic            wake_reg;

    // edge pulses, bus qualifiers and register strobes
    logic [PINS-1:0] rise_pulse;
    logic [PINS-1:0] fall_pulse;
    logic [PINS-1:0] hit;
    logic            change_irq_summary;
    logic            bus_req;
    logic            wr_now;
    logic            rd_now;
    logic            wr_irq_control;
    logic            wr_rise_enable;
    logic            wr_fall_enable;
    logic            wr_change_flag;
    logic            wr_evt_mask;
    logic            rd_evt_status;
    logic [PINS-1:0] evt_status_next;

    // ****************************************
    // edge detection
    // ****************************************
    // pins are taken as synchronous, so the detector only needs the
    // level of the previous cycle; an asynchronous source must be
    // synchronised outside this block or a slow edge may be doubled
    pcf_edge_det #(
        .WIDTH (PINS)
    ) u_edge (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_pin     (i_port_pin),
        .o_rise    (rise_pulse),
        .o_fall    (fall_pulse)
    );

    // enabled edges; detection ignores the change interrupt enable, so
    // a flag set while interrupts are off is still there when software
    // turns them on and raises the request at once
    assign hit = (rise_pulse & rise_enable_reg)   // R1 R9
               | (fall_pulse & fall_enable_reg);  // R2 R9

    // ****************************************
    // bus timing
    // ****************************************
    // one-cycle registered ack; write and read-clear act at the ack edge
    // ack drops after one cycle, so a master that holds its strobe
    // past ack starts a second access
    assign bus_req = i_wb_cyc & i_wb_stb;
    assign wr_now  = bus_req & ack_reg & i_wb_we & i_wb_sel[0];
    assign rd_now  = bus_req & ack_reg & ~i_wb_we;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    // full byte compare: aliases would make unmapped reads return live
    // data, which software could mistake for a real register
    function automatic logic hit_adr(input logic [ADR_WIDTH-1:0] adr,
                                     input logic [7:0] ofs);
        hit_adr = (adr == ofs);
    endfunction

    // ****************************************
    // register strobes
    // ****************************************
    // each strobe is high only in the commit cycle, on the edge that the
    // master sees ack, so a write or a read clear acts once per request
    assign wr_irq_control = wr_now & hit_adr(i_wb_adr, OFS_IRQ_CONTROL);
    assign wr_rise_enable = wr_now & hit_adr(i_wb_adr, OFS_RISE_ENABLE);
    assign wr_fall_enable = wr_now & hit_adr(i_wb_adr, OFS_FALL_ENABLE);
    assign wr_change_flag = wr_now & hit_adr(i_wb_adr, OFS_CHANGE_FLAG);
    assign wr_evt_mask    = wr_now & hit_adr(i_wb_adr, OFS_EVT_MASK);
    assign rd_evt_status  = rd_now & hit_adr(i_wb_adr, OFS_EVT_STATUS);

    // read data: low byte only, upper bits and unmapped addresses read zero
    // the word is loaded when the request is first seen and stands until
    // the next request, so it is ready in the ack cycle
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdat_reg <= '0;
        end else if (bus_req & ~ack_reg) begin
            rdat_reg <= '0;
            if (hit_adr(i_wb_adr, OFS_IRQ_CONTROL)) begin
                rdat_reg[BIT_GLOBAL_IRQ_EN]     <= global_irq_enable_reg;
                rdat_reg[BIT_PERIPHERAL_IRQ_EN] <= peripheral_irq_enable_reg;
                rdat_reg[BIT_CHANGE_IRQ_EN]     <= change_irq_enable_reg;
                rdat_reg[BIT_CHANGE_IRQ_SUM]    <= change_irq_summary;
            end else if (hit_adr(i_wb_adr, OFS_RISE_ENABLE)) begin
                rdat_reg[PINS-1:0] <= rise_enable_reg;
            end else if (hit_adr(i_wb_adr, OFS_FALL_ENABLE)) begin
                rdat_reg[PINS-1:0] <= fall_enable_reg;
            end else if (hit_adr(i_wb_adr, OFS_CHANGE_FLAG)) begin
                rdat_reg[PINS-1:0] <= change_flag_reg;  // R5 R6
            end else if (hit_adr(i_wb_adr, OFS_EVT_STATUS)) begin
                rdat_reg[PINS-1:0] <= evt_status_reg;
            end else if (hit_adr(i_wb_adr, OFS_EVT_MASK)) begin
                rdat_reg[PINS-1:0] <= evt_mask_reg;
            end
        end
    end

    // bus outputs come straight from their flip-flops
    assign o_wb_dat = rdat_reg;
    assign o_wb_ack = ack_reg;

    // ****************************************
    // control registers
    // ****************************************
    // global enable: stored and read back only; the gating with it is
    // done by the interrupt controller outside this block
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            global_irq_enable_reg <= RST_BIT;
        end else if (wr_irq_control) begin
            global_irq_enable_reg <= i_wb_dat[BIT_GLOBAL_IRQ_EN];
        end
    end

    // peripheral enable: stored and read back only, like the global one
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            peripheral_irq_enable_reg <= RST_BIT;
        end else if (wr_irq_control) begin
            peripheral_irq_enable_reg <= i_wb_dat[BIT_PERIPHERAL_IRQ_EN];
        end
    end

    // change interrupt enable; it gates the request lines and the wake,
    // never the detection, so no edge is lost while it is off
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            change_irq_enable_reg <= RST_BIT;
        end else if (wr_irq_control) begin
            change_irq_enable_reg <= i_wb_dat[BIT_CHANGE_IRQ_EN];  // R4 R9
        end
    end

    // rising-edge enables, one bit per pin; upper data bits are dropped
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rise_enable_reg <= RST_PIN_BITS;
        end else if (wr_rise_enable) begin
            rise_enable_reg <= i_wb_dat[PINS-1:0];
        end
    end

    // falling-edge enables, one bit per pin
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fall_enable_reg <= RST_PIN_BITS;
        end else if (wr_fall_enable) begin
            fall_enable_reg <= i_wb_dat[PINS-1:0];
        end
    end

    // event mask; a masked event is still recorded in the status register
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            evt_mask_reg <= RST_PIN_BITS;
        end else if (wr_evt_mask) begin
            evt_mask_reg <= i_wb_dat[PINS-1:0];
        end
    end

    // ****************************************
    // change flags
    // ****************************************
    // a new edge is ORed in after the written value, so a clearing
    // write can never swallow an edge arriving in the same cycle
    // writing zero to a flag that was set after software last read it
    // loses that edge; software should clear only the bits it has seen
    always_comb begin
        change_flag_next = change_flag_reg;
        if (wr_change_flag) begin
            change_flag_next = i_wb_dat[PINS-1:0];  // R3
        end
        change_flag_next = change_flag_next | hit;  // R1 R2 R7
    end

    // flag storage; reset clears every flag
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            change_flag_reg <= RST_PIN_BITS;  // R3
        end else begin
            change_flag_reg <= change_flag_next;
        end
    end

    // summary bit of the interrupt control register, read only
    assign change_irq_summary = |change_flag_reg;  // R8

    // request follows the flags, gated by the change interrupt enable;
    // it is a level, so it stays up until every flag has been cleared
    // or the enable is turned off
    assign o_change_irq = change_irq_summary & change_irq_enable_reg;  // R4

    // ****************************************
    // event status and interrupt line
    // ****************************************
    // sticky per-pin events, cleared by reading; the read data is taken
    // one edge before the commit, so only the bits that software was
    // shown are cleared and an event landing in between waits for the
    // next read instead of being lost
    always_comb begin
        evt_status_next = evt_status_reg;
        if (rd_evt_status) begin
            evt_status_next = evt_status_reg & ~rdat_reg[PINS-1:0];
        end
        evt_status_next = evt_status_next | hit;  // set wins over the clear
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            evt_status_reg <= RST_PIN_BITS;
        end else begin
            evt_status_reg <= evt_status_next;
        end
    end

    // level line: high while an unmasked status bit is set; the change
    // interrupt enable gates it as well, so one bit silences both lines
    assign o_irq = change_irq_enable_reg & (|(evt_status_reg & evt_mask_reg));  // R4

    // ****************************************
    // wake from sleep
    // ****************************************
    // the flag is written in the same edge as the wake pulse, so it is
    // already valid when the core resumes
    // the pulse lasts one cycle; whoever wakes the core must catch it,
    // since the request level alone says nothing about sleep
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= i_sleep & change_irq_enable_reg & (|hit);  // R10
        end
    end

    assign o_wake = wake_reg;
endmodule

// [pcf_pin_model.sv]
`timescale 1ns/100ps
// ********************************
// pin source
// ********************************
module pcf_pin_model (
    // clock
    input  wire logic       i_sys_clk,
    // levels asked for
    input  wire logic [3:0] i_level,
    // pin levels
    output logic      [3:0] o_pin
);
    // levels move one clock after the ask, so no pulse is narrower than a clock
    always @(posedge i_sys_clk) begin
        o_pin <= i_level;
    end
endmodule

// [pcf_top_checker.sv]
`timescale 1ns/100ps
// ********************************
// port checks
// ********************************
module pcf_top_checker
    import pcf_pkg::*;
#(
    parameter int unsigned PINS = 4
) (
    // clock, reset and bus
    input wire logic                 i_sys_clk,
    input wire logic                 i_sys_rst,
    input wire logic                 i_wb_cyc,
    input wire logic                 i_wb_stb,
    input wire logic                 i_wb_we,
    input wire logic [ADR_WIDTH-1:0] i_wb_adr,
    input wire logic [DAT_WIDTH-1:0] o_wb_dat,
    input wire logic                 o_wb_ack,
    // pins and processor side
    input wire logic [PINS-1:0]      i_port_pin,
    input wire logic                 i_sleep,
    input wire logic                 o_change_irq,
    input wire logic                 o_wake
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);
    // read data was loaded one edge before ack, so compare with the earlier irq
    a_summary_and_gate: assert property (o_wb_ack && !i_wb_we && i_wb_adr == OFS_IRQ_CONTROL
        |-> (o_wb_dat[0] & o_wb_dat[3]) == $past(o_change_irq)) else $error("summary bad");
    a_flag_top_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr == OFS_CHANGE_FLAG
        |-> o_wb_dat[7:4] == 4'h0) else $error("flag upper bits set");
    a_wake_cause: assert property (o_wake |-> o_change_irq && $past(i_sleep))
        else $error("wake without cause");
    a_flag_rise_cause: assert property ($rose(o_change_irq)
        |-> $past(i_port_pin) != $past(i_port_pin, 2) || $past(o_wb_ack && i_wb_we))
        else $error("irq rose without edge or write");
    a_flag_fall_cause: assert property ($fell(o_change_irq) |-> $past(o_wb_ack && i_wb_we))
        else $error("irq fell without write");
    a_ack_latency: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("ack late");
    a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack too long");
    a_unmapped_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr > OFS_EVT_MASK
        |-> o_wb_dat == 32'h0000_0000) else $error("unmapped read not zero");
endmodule
bind pcf_top pcf_top_checker #(.PINS(PINS)) i_pcf_top_checker (.i_sys_clk, .i_sys_rst,
    .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack, .i_port_pin,
    .i_sleep, .o_change_irq, .o_wake);

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
    import pcf_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0, sleep = 1'b0, woke = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  lvl = 4'h0, lvl_next = 4'h0, pins, r, sel = 4'hf;
    logic [31:0] wdat = 32'h0000_0000, rdat, exp_q[$];
    logic        ack, chg, wake, irq;
    int          errors = 0, total_checks = 0;
    // ********************************
    // clock, parts and watchers
    // ********************************
    initial forever #25 clk = ~clk;
    pcf_pin_model i_pcf_pin_model (.i_sys_clk(clk), .i_level(lvl), .o_pin(pins));
    pcf_top i_pcf_top (.i_sys_clk(clk), .i_sys_rst(rst), .i_wb_cyc(req), .i_wb_stb(req),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_port_pin(pins), .i_sleep(sleep), .o_change_irq(chg),
        .o_wake(wake), .o_irq(irq));
    // read data is taken at the ack edge and matched with the oldest note
    always @(posedge clk) begin
        if (ack && !we) check(rdat, exp_q.pop_front());
        if (wake) woke <= 1'b1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // one bus cycle; on a read d is the expected data; pins move one clock after the request
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        lvl <= lvl_next;
        if (!w) exp_q.push_back(d);
        // ack is looked at on the rising edge; the request stands through it
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            errors++;
            results();
        end
        req <= 1'b0;
        @(posedge clk);
    endtask
    // ********************************
    // main sequence
    // ********************************
    initial begin
        void'($urandom(98169));
        r = (4'($urandom) | 4'h1) & 4'h7;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) bus(1'b0, 8'(4 * i), 32'h0);
        bus(1'b1, OFS_RISE_ENABLE, {28'h0, r});
        bus(1'b1, OFS_FALL_ENABLE, {28'h0, ~r});
        lvl_next = 4'hf;
        bus(1'b0, OFS_CHANGE_FLAG, 32'h0);
        bus(1'b0, OFS_CHANGE_FLAG, {28'h0, r});
        bus(1'b0, OFS_IRQ_CONTROL, 32'h1);
        check(32'(chg), 32'h0);
        lvl_next = 4'h0;
        bus(1'b1, OFS_EVT_MASK, 32'h0);
        bus(1'b0, OFS_CHANGE_FLAG, 32'hf);
        bus(1'b1, OFS_CHANGE_FLAG, 32'h0);
        bus(1'b0, OFS_CHANGE_FLAG, 32'h0);
        bus(1'b1, OFS_IRQ_CONTROL, 32'h8);
        bus(1'b0, OFS_EVT_STATUS, 32'hf);
        lvl_next = 4'h1;
        // the pin edge lands in the very cycle that the clearing write commits
        bus(1'b1, OFS_CHANGE_FLAG, 32'h0);
        bus(1'b0, OFS_CHANGE_FLAG, 32'h1);
        @(posedge clk);
        check(32'(chg), 32'h1);
        check(32'(irq), 32'h0);
        bus(1'b1, OFS_EVT_MASK, 32'hf);
        @(posedge clk);
        check(32'(irq), 32'h1);
        bus(1'b0, OFS_EVT_STATUS, 32'h1);
        @(posedge clk);
        check(32'(irq), 32'h0);
        sleep <= 1'b1;
        bus(1'b1, OFS_FALL_ENABLE, 32'hf);
        lvl_next = 4'h0;
        bus(1'b0, OFS_IRQ_CONTROL, 32'h9);
        bus(1'b0, OFS_CHANGE_FLAG, 32'h1);
        check(32'(woke), 32'h1);
        // enable bits round trip; the summary bit cannot be written
        bus(1'b1, OFS_IRQ_CONTROL, 32'hcf);
        bus(1'b0, OFS_IRQ_CONTROL, 32'hc9);
        // a write with the low byte lane off leaves the register alone
        sel <= 4'he;
        bus(1'b1, OFS_RISE_ENABLE, 32'h0);
        sel <= 4'hf;
        bus(1'b0, OFS_RISE_ENABLE, {28'h0, r});
        // clearing the last flag drops the request
        bus(1'b1, OFS_CHANGE_FLAG, 32'h0);
        check(32'(chg), 32'h0);
        bus(1'b0, OFS_IRQ_CONTROL, 32'hc8);
        results();
    end
endmodule
